/* include/wake_status_pkg.sv */
// constants shared by the wake event status bank
package wake_status_pkg;
  localparam int          DATA_W          = 8;
  localparam int          ADDR_W          = 8;
  localparam int          NUM_REGS        = 4;
  localparam logic [7:0]  OFFS_GROUP1     = 8'h05;
  localparam logic [7:0]  OFFS_GROUP2     = 8'h06;
  localparam logic [7:0]  OFFS_GROUP3_MIX = 8'h07;
  localparam logic [7:0]  OFFS_GROUP5     = 8'h08;
  localparam logic [7:0]  STATUS_RESET    = 8'h00;
  localparam logic [7:0]  UNMAPPED_READ   = 8'h00;
  localparam int          DEVIRQ_BIT      = 3;
  typedef logic [DATA_W-1:0] byte_t;
endpackage

/* rtl/wake_status_reg.sv */
// one eight-bit sticky wake status register, write one to clear
`timescale 1ns/1ps
module wake_status_reg
  import wake_status_pkg::*;
(
  // clock and standby reset
  input  wire logic              ref_clk,
  input  wire logic              standbyPorReset,
  // event and clear
  input  wire logic [DATA_W-1:0] eventPulse,
  input  wire logic              clearStrobe,
  input  wire logic [DATA_W-1:0] clearData,
  // state
  output logic      [DATA_W-1:0] status
);
  typedef struct packed {
    logic [DATA_W-1:0] bits;
  } state_s;

  state_s st;
  state_s next_st;

  always_comb begin
    next_st = st;
    if (clearStrobe) begin
      next_st.bits = st.bits & ~clearData;
    end
    // set wins over clear in the same cycle
    next_st.bits = next_st.bits | eventPulse;
  end

  always_ff @(posedge ref_clk) begin
    if (standbyPorReset) begin
      st <= '{bits: STATUS_RESET};
    end else begin
      st <= next_st;
    end
  end

  assign status = st.bits;
endmodule

/* rtl/wake_event_status_bank.sv */
// wake event status bank: four sticky registers and wake output join
`timescale 1ns/1ps

module wake_event_status_bank (
  // clock and resets
  input  wire logic                          ref_clk,
  input  wire logic                          reset,
  input  wire logic                          mainSupplyReset,
  input  wire logic                          softReset,
  input  wire logic                          hardReset,
  // register port
  input  wire logic [wake_status_pkg::ADDR_W-1:0] regAddr,
  input  wire logic                          regWrite,
  input  wire logic                          regRead,
  input  wire logic [wake_status_pkg::DATA_W-1:0] regWriteData,
  output logic      [wake_status_pkg::DATA_W-1:0] regReadData,
  // wake sources, asynchronous pins
  input  wire logic [7:0]                    pinGroup1,
  input  wire logic [7:0]                    pinGroup2,
  input  wire logic [3:0]                    pinGroup3,
  input  wire logic                          pinG4L1,
  input  wire logic                          pinG4L3,
  input  wire logic [1:0]                    pinG6,
  input  wire logic [7:0]                    pinGroup5,
  input  wire logic                          groupedDeviceIrqStatus,
  // enables from the enable registers
  input  wire logic [31:0]                   sourceEnable,
  input  wire logic                          globalWakeEnable,
  // wake output, active low
  output logic                               wakeOutput_n
);
  import wake_status_pkg::*;

  localparam int NSRC = NUM_REGS * DATA_W;

  typedef struct packed {
    // pin synchroniser, first and second flop
    logic [NSRC-1:0] syncA;
    logic [NSRC-1:0] syncB;
    // edge detect history
    logic [NSRC-1:0] prev;
    // registered read data and wake level
    byte_t           readData;
    logic            wake_n;
  } state_s;

  // standby reset image; every field named so nothing is left unknown
  localparam state_s ST_RESET = '{
    syncA:    '0,
    syncB:    '0,
    prev:     '0,
    readData: STATUS_RESET,
    wake_n:   1'b1
  };

  state_s st;
  state_s next_st;

  // raw, edge, stored and armed views of all sources
  logic [NSRC-1:0]     rawSrc;
  logic [NSRC-1:0]     eventVec;
  logic [NSRC-1:0]     statusVec;
  logic [NSRC-1:0]     armedVec;
  // per-register slices
  byte_t               eventGroup1;
  byte_t               eventGroup2;
  byte_t               eventGroup3Mix;
  byte_t               eventGroup5;
  byte_t               statusGroup1;
  byte_t               statusGroup2;
  byte_t               statusGroup3Mix;
  byte_t               statusGroup5;
  // register decode, readback and wake join
  logic [NUM_REGS-1:0] addrHit;
  logic [NUM_REGS-1:0] clearSel;
  byte_t               readMux;
  logic [NUM_REGS-1:0] regWakeReq;
  logic                anyWakeReq;

  // source order within each register
  always_comb begin
    // offset 05: group 1 lines 0 to 7
    rawSrc[0]  = pinGroup1[0];
    rawSrc[1]  = pinGroup1[1];
    rawSrc[2]  = pinGroup1[2];
    rawSrc[3]  = pinGroup1[3];
    rawSrc[4]  = pinGroup1[4];
    rawSrc[5]  = pinGroup1[5];
    rawSrc[6]  = pinGroup1[6];
    rawSrc[7]  = pinGroup1[7];

    // offset 06: group 2 with the device irq in bit 3
    // group 2 line 3 is not a wake source and stays unread
    rawSrc[8]  = pinGroup2[0];
    rawSrc[9]  = pinGroup2[1];
    rawSrc[10] = pinGroup2[2];
    rawSrc[11] = groupedDeviceIrqStatus;
    rawSrc[12] = pinGroup2[4];
    rawSrc[13] = pinGroup2[5];
    rawSrc[14] = pinGroup2[6];
    rawSrc[15] = pinGroup2[7];

    // offset 07: group 3 lines 0-3, group 4 l1/l3, group 6 l0/l1
    rawSrc[16] = pinGroup3[0];
    rawSrc[17] = pinGroup3[1];
    rawSrc[18] = pinGroup3[2];
    rawSrc[19] = pinGroup3[3];
    rawSrc[20] = pinG4L1;
    rawSrc[21] = pinG4L3;
    rawSrc[22] = pinG6[0];
    rawSrc[23] = pinG6[1];

    // offset 08: group 5 lines 0 to 7
    rawSrc[24] = pinGroup5[0];
    rawSrc[25] = pinGroup5[1];
    rawSrc[26] = pinGroup5[2];
    rawSrc[27] = pinGroup5[3];
    rawSrc[28] = pinGroup5[4];
    rawSrc[29] = pinGroup5[5];
    rawSrc[30] = pinGroup5[6];
    rawSrc[31] = pinGroup5[7];
  end

  // a rising edge of a synchronised level is the wake event;
  // a level held through standby reset still counts once
  assign eventVec = st.syncB & ~st.prev;

  assign eventGroup1    = eventVec[7:0];
  assign eventGroup2    = eventVec[15:8];
  assign eventGroup3Mix = eventVec[23:16];
  assign eventGroup5    = eventVec[31:24];

  // one-hot register select shared by reads and writes
  always_comb begin
    addrHit = '0;
    if (regAddr == OFFS_GROUP1) begin
      addrHit[0] = 1'b1;
    end else if (regAddr == OFFS_GROUP2) begin
      addrHit[1] = 1'b1;
    end else if (regAddr == OFFS_GROUP3_MIX) begin
      addrHit[2] = 1'b1;
    end else if (regAddr == OFFS_GROUP5) begin
      addrHit[3] = 1'b1;
    end
  end

  // unmapped writes select nothing and are dropped
  always_comb begin
    clearSel = '0;
    if (regWrite) begin
      clearSel = addrHit;
    end
  end

  // host-side resets are left out on purpose: status must outlive them
  // offset 05
  wake_status_reg uGroup1 (
    .ref_clk         (ref_clk),
    .standbyPorReset (reset),
    .eventPulse      (eventGroup1),
    .clearStrobe     (clearSel[0]),
    .clearData       (regWriteData),
    .status          (statusGroup1)
  );

  // offset 06
  wake_status_reg uGroup2 (
    .ref_clk         (ref_clk),
    .standbyPorReset (reset),
    .eventPulse      (eventGroup2),
    .clearStrobe     (clearSel[1]),
    .clearData       (regWriteData),
    .status          (statusGroup2)
  );

  // offset 07
  wake_status_reg uGroup3Mix (
    .ref_clk         (ref_clk),
    .standbyPorReset (reset),
    .eventPulse      (eventGroup3Mix),
    .clearStrobe     (clearSel[2]),
    .clearData       (regWriteData),
    .status          (statusGroup3Mix)
  );

  // offset 08
  wake_status_reg uGroup5 (
    .ref_clk         (ref_clk),
    .standbyPorReset (reset),
    .eventPulse      (eventGroup5),
    .clearStrobe     (clearSel[3]),
    .clearData       (regWriteData),
    .status          (statusGroup5)
  );

  assign statusVec = {statusGroup5, statusGroup3Mix,
                      statusGroup2, statusGroup1};

  // a set bit only arms the wake output when its own enable is on
  always_comb begin
    // offset 05
    armedVec[0]  = statusVec[0]  & sourceEnable[0];
    armedVec[1]  = statusVec[1]  & sourceEnable[1];
    armedVec[2]  = statusVec[2]  & sourceEnable[2];
    armedVec[3]  = statusVec[3]  & sourceEnable[3];
    armedVec[4]  = statusVec[4]  & sourceEnable[4];
    armedVec[5]  = statusVec[5]  & sourceEnable[5];
    armedVec[6]  = statusVec[6]  & sourceEnable[6];
    armedVec[7]  = statusVec[7]  & sourceEnable[7];

    // offset 06
    armedVec[8]  = statusVec[8]  & sourceEnable[8];
    armedVec[9]  = statusVec[9]  & sourceEnable[9];
    armedVec[10] = statusVec[10] & sourceEnable[10];
    armedVec[11] = statusVec[11] & sourceEnable[11];
    armedVec[12] = statusVec[12] & sourceEnable[12];
    armedVec[13] = statusVec[13] & sourceEnable[13];
    armedVec[14] = statusVec[14] & sourceEnable[14];
    armedVec[15] = statusVec[15] & sourceEnable[15];

    // offset 07
    armedVec[16] = statusVec[16] & sourceEnable[16];
    armedVec[17] = statusVec[17] & sourceEnable[17];
    armedVec[18] = statusVec[18] & sourceEnable[18];
    armedVec[19] = statusVec[19] & sourceEnable[19];
    armedVec[20] = statusVec[20] & sourceEnable[20];
    armedVec[21] = statusVec[21] & sourceEnable[21];
    armedVec[22] = statusVec[22] & sourceEnable[22];
    armedVec[23] = statusVec[23] & sourceEnable[23];

    // offset 08
    armedVec[24] = statusVec[24] & sourceEnable[24];
    armedVec[25] = statusVec[25] & sourceEnable[25];
    armedVec[26] = statusVec[26] & sourceEnable[26];
    armedVec[27] = statusVec[27] & sourceEnable[27];
    armedVec[28] = statusVec[28] & sourceEnable[28];
    armedVec[29] = statusVec[29] & sourceEnable[29];
    armedVec[30] = statusVec[30] & sourceEnable[30];
    armedVec[31] = statusVec[31] & sourceEnable[31];
  end

  assign regWakeReq[0] = |armedVec[7:0];
  assign regWakeReq[1] = |armedVec[15:8];
  assign regWakeReq[2] = |armedVec[23:16];
  assign regWakeReq[3] = |armedVec[31:24];
  assign anyWakeReq    = |regWakeReq;

  // readback select; unmapped offsets read as zero
  always_comb begin
    readMux = UNMAPPED_READ;
    if (addrHit[0]) begin
      readMux = statusGroup1;
    end else if (addrHit[1]) begin
      readMux = statusGroup2;
    end else if (addrHit[2]) begin
      readMux = statusGroup3Mix;
    end else if (addrHit[3]) begin
      readMux = statusGroup5;
    end
  end

  always_comb begin
    next_st = st;
    // two flops before any logic reads a pin, then the history flop
    next_st.syncA[7:0]   = rawSrc[7:0];
    next_st.syncB[7:0]   = st.syncA[7:0];
    next_st.prev[7:0]    = st.syncB[7:0];
    next_st.syncA[15:8]  = rawSrc[15:8];
    next_st.syncB[15:8]  = st.syncA[15:8];
    next_st.prev[15:8]   = st.syncB[15:8];
    next_st.syncA[23:16] = rawSrc[23:16];
    next_st.syncB[23:16] = st.syncA[23:16];
    next_st.prev[23:16]  = st.syncB[23:16];
    next_st.syncA[31:24] = rawSrc[31:24];
    next_st.syncB[31:24] = st.syncA[31:24];
    next_st.prev[31:24]  = st.syncB[31:24];
    // reads only sample, never modify status
    if (regRead) begin
      next_st.readData = readMux;
    end
    // global gate applied last, after per-source arming
    next_st.wake_n = ~(globalWakeEnable & anyWakeReq);
  end

  // host-side resets leave this state alone as well
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st <= ST_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign regReadData  = st.readData;
  assign wakeOutput_n = st.wake_n;
endmodule

/* bench/wake_event_status_bank_props.sv */
// port assertions for the wake status bank
`timescale 1ns/1ps
module wake_event_status_bank_props
  import wake_status_pkg::*;
(
  input wire logic        ref_clk, reset, regWrite, regRead,
  input wire logic        globalWakeEnable, wakeOutput_n,
  input wire logic [7:0]  regAddr, regReadData,
  input wire logic [31:0] sourceEnable
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  property p_rst_rd; $fell(reset) |-> regReadData == 8'h00; endproperty
  a_rst_rd: assert property (p_rst_rd) else $error("reset read");
  property p_rst_wk; $fell(reset) |-> wakeOutput_n [*2]; endproperty
  a_rst_wk: assert property (p_rst_wk) else $error("reset wake");
  property p_unmap; regRead && !(regAddr inside {[8'h05:8'h08]}) ##1
    !regRead |=> regReadData == 8'h00; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read");
  property p_hold; !regRead && !$past(regRead) |=> $stable(regReadData);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  // a set enabled bit keeps the output low until a write
  property p_sticky; !wakeOutput_n && !$past(regWrite) && globalWakeEnable
    && $stable(sourceEnable) |=> !wakeOutput_n; endproperty
  a_sticky: assert property (p_sticky) else $error("wake lost");
  property p_gwe; !wakeOutput_n |-> $past(globalWakeEnable); endproperty
  a_gwe: assert property (p_gwe) else $error("wake while off");
  property p_srcen; !wakeOutput_n |-> $past(sourceEnable) != 32'h0;
  endproperty
  a_srcen: assert property (p_srcen) else $error("no source on");
  property p_rise; $rose(wakeOutput_n) |-> $past(regWrite, 2) ||
    $past(reset) || !$past(globalWakeEnable) ||
    $past(sourceEnable) != $past(sourceEnable, 2); endproperty
  a_rise: assert property (p_rise) else $error("wake dropped");
endmodule
bind wake_event_status_bank wake_event_status_bank_props u_props (.*);

/* bench/wake_event_status_bank_tb.sv */
// self-checking bench for the wake status bank
`timescale 1ns/1ps
module wake_event_status_bank_tb;
  import wake_status_pkg::*;
  logic        ref_clk, reset, mainSupplyReset, softReset, hardReset;
  logic        regWrite, regRead, pinG4L1, pinG4L3, globalWakeEnable;
  logic        groupedDeviceIrqStatus, wakeOutput_n;
  logic [7:0]  regAddr, regWriteData, regReadData;
  logic [7:0]  pinGroup1, pinGroup2, pinGroup5;
  logic [3:0]  pinGroup3;
  logic [1:0]  pinG6;
  logic [31:0] sourceEnable;
  logic [32:0] src;
  int          failures = 0, n_compared = 0, cyc = 0;
  byte_t       offs [5] = '{8'h05, 8'h06, 8'h07, 8'h08, 8'h09};
  byte_t       exp1 [5] = '{8'h81, 8'h39, 8'h9a, 8'h5a, 8'h00};
  assign {pinGroup1, pinGroup2, pinGroup3, pinG4L1, pinG4L3, pinG6,
          pinGroup5, groupedDeviceIrqStatus} = src;
  wake_event_status_bank dut (.*);
  initial begin
    ref_clk = 0;
    forever #20 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 1000) begin
      failures++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("failures=%0d n_compared=%0d", failures, n_compared);
    if (failures == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cmp(input byte_t got, want);
    n_compared++;
    if (got !== want) begin
      failures++;
      $display("[ERR] %0t got %h want %h", $time, got, want);
    end
  endtask
  task automatic acc(input logic w, input byte_t a, d);
    @(posedge ref_clk) #1;
    {regWrite, regRead, regAddr, regWriteData} = {w, !w, a, d};
    @(posedge ref_clk) #1;
    {regWrite, regRead} = 2'b00;
  endtask
  // data stands until the next read, so one spare edge is safe
  task automatic chk(input byte_t a, want);
    acc(1'b0, a, 8'h00);
    @(posedge ref_clk) #1;
    cmp(regReadData, want);
  endtask
  initial begin
    reset = 1;
    {regWrite, regRead, regAddr, regWriteData, src} = '0;
    {mainSupplyReset, softReset, hardReset, globalWakeEnable} = '0;
    sourceEnable = '0;
    repeat (16) @(posedge ref_clk);
    #1 reset = 0;
    foreach (offs[i]) chk(offs[i], 8'h00);
    src = {8'h81, 8'h31, 4'ha, 2'b10, 2'b10, 8'h5a, 1'b1};
    repeat (4) @(posedge ref_clk);
    #1 src = '0;
    foreach (offs[i]) chk(offs[i], exp1[i]);
    cmp({7'h0, wakeOutput_n}, 8'h01);
    acc(1'b1, 8'h05, 8'h00);
    chk(8'h05, 8'h81);
    acc(1'b1, 8'h05, 8'h7f);
    chk(8'h05, 8'h80);
    sourceEnable = 32'h80;
    {mainSupplyReset, softReset, hardReset, globalWakeEnable} = '1;
    repeat (3) @(posedge ref_clk);
    #1 {mainSupplyReset, softReset, hardReset} = '0;
    cmp({7'h0, wakeOutput_n}, 8'h00);
    chk(8'h05, 8'h80);
    // event lands on the same edge as the clear
    src[25] = 1'b1;
    @(posedge ref_clk);
    acc(1'b1, 8'h05, 8'h01);
    chk(8'h05, 8'h81);
    src = '0;
    reset = 1;
    @(posedge ref_clk) #1 reset = 0;
    chk(8'h05, 8'h00);
    wrap_up();
  end
endmodule
